// file: acs_pkg.sv
// How it works
// R1 - In power-down, writing 1 to the start_status_bit with the mode bit at 1 in the same word starts one single conversion; writing 0 does nothing.
// R2 - Writes to the start_status_bit are ignored while a conversion runs.
// R3 - The start_status_bit reads 0 while converting and 1 when idle, and resets to 1.
// R4 - The input_select_field picks positive and negative inputs, 000 in0/in1 through 111 in3/ground, default 000.
// R5 - The gain_range_field sets the full_scale_range, 010 being the reset default and 101 to 111 all the smallest range.
// R6 - The mode bit selects continuous conversion at 0 and single-shot with power-down at 1, reset value 1.
// R7 - The rate_field sets the sample rate from 128 to 3300 per second, 100 being the reset default.
// R8 - The host loads pointer 01 before touching this register; reads return the pointed register, though rdata_o shows this register whatever ptr_i holds.
// R9 - In ready signalling the ready output mirrors the start_status_bit in single-shot and pulses per conversion in continuous mode.
// R10 - After a single-shot conversion the device powers down and the start_status_bit reads 1 again.
package acs_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam logic [1:0] PTR_SETUP = 2'h1;
  localparam int START_BIT = 15;
  localparam int SEL_LSB = 12;
  localparam int GAIN_LSB = 9;
  localparam int MODE_BIT = 8;
  localparam int RATE_LSB = 5;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [2:0] GAIN_RESET = 3'h2;
  localparam logic MODE_RESET = 1'h1;
  localparam logic [2:0] RATE_RESET = 3'h4;
  localparam logic [4:0] LOW_RESET = 5'h03;
  localparam logic START_RESET = 1'h1;
  localparam int LOW_LSB = 0;
  localparam logic MODE_CONT = 1'h0;
  // Samples per second for each rate code
  localparam int RATE_SPS [8] = '{128, 250, 490, 920, 1600, 2400, 3300, 3300};
  localparam int CNT_W = 20;

  typedef enum logic [1:0] {ACS_IDLE, ACS_SINGLE, ACS_CONT} acs_state_t;

  typedef struct packed {
    logic [2:0] input_select_field;
    logic [2:0] gain_range_field;
    logic mode;
    logic [2:0] rate_field;
    logic [4:0] low_bits;
  } acs_setup_t;
endpackage : acs_pkg

// file: acs_rate_timer.sv
`timescale 1ns/10ps
// Counts out one conversion period for the selected rate code
module acs_rate_timer #(
  parameter int CLK_HZ = acs_pkg::CLK_HZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic run_i,
  input wire logic [2:0] rate_i,
  // Status
  output logic done_o
);
  typedef struct packed {
    logic [acs_pkg::CNT_W-1:0] cnt;
    logic done;
  } acs_tmr_t;

  acs_tmr_t st_reg;
  acs_tmr_t st_next;
  logic [acs_pkg::CNT_W-1:0] period;

  always_comb begin
    period = acs_pkg::CNT_W'(CLK_HZ / acs_pkg::RATE_SPS[rate_i]); // see R7
    st_next = st_reg;
    st_next.done = 1'b0;
    if (!run_i) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt + acs_pkg::CNT_W'(1) >= period) begin
      st_next.cnt = '0;
      st_next.done = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + acs_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done_o = st_reg.done;
endmodule : acs_rate_timer

// file: acs_setup_reg.sv
`timescale 1ns/10ps
module acs_setup_reg #(
  parameter int CLK_HZ = acs_pkg::CLK_HZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register access from the serial front end
  input wire logic [1:0] ptr_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  // Converter control
  output logic [2:0] input_select_o,
  output logic [2:0] gain_range_o,
  output logic [2:0] rate_o,
  output logic converting_o,
  output logic conv_done_o,
  output logic ready_o
);
  typedef struct packed {
    acs_pkg::acs_setup_t cfg;
    acs_pkg::acs_state_t state;
    logic [15:0] rdata;
  } acs_top_t;

  acs_top_t st_reg;
  acs_top_t st_next;
  logic done;
  logic busy;
  logic start_status;
  logic sel_wr;
  logic start_req;

  acs_rate_timer #(
    .CLK_HZ(CLK_HZ)
  ) u_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(busy),
    .rate_i(st_reg.cfg.rate_field),
    .done_o(done)
  );

  // Anything but idle is a conversion in progress
  assign busy = (st_reg.state != acs_pkg::ACS_IDLE);
  assign start_status = !busy; // see R3
  assign sel_wr = wr_i && (ptr_i == acs_pkg::PTR_SETUP); // see R8

  // Only an idle device takes a start, and only with single-shot mode in
  // the written word; a start written with mode 0 is left to the loop
  assign start_req = sel_wr && !busy && // see R2
                     wdata_i[acs_pkg::START_BIT] && // see R1
                     (wdata_i[acs_pkg::MODE_BIT] != acs_pkg::MODE_CONT);

  // Splits a written word into the stored fields; the start bit is a
  // command and never lands in storage
  function automatic acs_pkg::acs_setup_t take_fields(
    input logic [15:0] word
  );
    acs_pkg::acs_setup_t f;
    f.input_select_field = word[acs_pkg::SEL_LSB +: 3]; // see R4
    f.gain_range_field = word[acs_pkg::GAIN_LSB +: 3]; // see R5
    f.mode = word[acs_pkg::MODE_BIT]; // see R6
    f.rate_field = word[acs_pkg::RATE_LSB +: 3]; // see R7
    f.low_bits = word[acs_pkg::LOW_LSB +: 5];
    return f;
  endfunction : take_fields

  // Builds the read-back word from the status and the stored fields
  function automatic logic [15:0] show_fields(
    input logic status,
    input acs_pkg::acs_setup_t f
  );
    return {status, f.input_select_field, f.gain_range_field, f.mode,
            f.rate_field, f.low_bits};
  endfunction : show_fields

  // Advances the conversion state on its own; a host start is applied
  // afterwards so that it can override an idle step
  function automatic acs_pkg::acs_state_t step_state(
    input acs_pkg::acs_state_t state,
    input logic mode,
    input logic period_done
  );
    acs_pkg::acs_state_t step;
    step = state;
    case (state)
      acs_pkg::ACS_IDLE: begin
        if (mode == acs_pkg::MODE_CONT) begin
          step = acs_pkg::ACS_CONT; // see R6
        end
      end
      acs_pkg::ACS_SINGLE: begin
        // Back to power-down once the requested result is in
        if (period_done) begin
          step = acs_pkg::ACS_IDLE; // see R10
        end
      end
      acs_pkg::ACS_CONT: begin
        // Writing single-shot mode stops the free-running loop
        if (mode != acs_pkg::MODE_CONT) begin
          step = acs_pkg::ACS_IDLE; // see R6
        end
      end
      default: begin
        step = acs_pkg::ACS_IDLE;
      end
    endcase
    return step;
  endfunction : step_state

  always_comb begin
    st_next = st_reg;
    st_next.state = step_state(st_reg.state, st_reg.cfg.mode, done);
    if (sel_wr) begin
      st_next.cfg = take_fields(wdata_i); // see R4, R5, R6, R7
    end
    if (start_req) begin
      st_next.state = acs_pkg::ACS_SINGLE; // see R1, R2
    end
    // Read-back is built from the next state, so the status bit and the
    // fields never trail the state they describe by a cycle
    st_next.rdata = show_fields(st_next.state == acs_pkg::ACS_IDLE,
                                st_next.cfg); // see R3
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg.cfg.input_select_field <= acs_pkg::SEL_RESET;
      st_reg.cfg.gain_range_field <= acs_pkg::GAIN_RESET;
      st_reg.cfg.mode <= acs_pkg::MODE_RESET;
      st_reg.cfg.rate_field <= acs_pkg::RATE_RESET;
      st_reg.cfg.low_bits <= acs_pkg::LOW_RESET;
      st_reg.state <= acs_pkg::ACS_IDLE;
      st_reg.rdata <= {acs_pkg::START_RESET, acs_pkg::SEL_RESET,
                       acs_pkg::GAIN_RESET, acs_pkg::MODE_RESET,
                       acs_pkg::RATE_RESET, acs_pkg::LOW_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;
  assign input_select_o = st_reg.cfg.input_select_field;
  assign gain_range_o = st_reg.cfg.gain_range_field;
  assign rate_o = st_reg.cfg.rate_field;
  assign converting_o = busy;
  assign conv_done_o = done;
  // Single-shot mirrors status, continuous pulses once per result; it
  // follows the mode bit so it agrees with the read-back as mode changes
  assign ready_o = (st_reg.cfg.mode == acs_pkg::MODE_CONT) ?
                   done : start_status; // see R9
endmodule : acs_setup_reg

// file: acs_setup_sva.sv
`timescale 1ns/10ps
module acs_setup_sva (
  // Watched ports
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] ptr_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic converting_o,
  input wire logic conv_done_o,
  input wire logic ready_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  start_single_a: assert property (wr_i && ptr_i == 2'h1 && wdata_i[15]
    && wdata_i[8] && !converting_o |=> converting_o) else $error("no start");
  busy_hold_a: assert property (wr_i && ptr_i == 2'h1 && rdata_o[8]
    && $past(rdata_o[8]) && converting_o && !conv_done_o |=> converting_o)
    else $error("busy lost");
  status_read_a: assert property (converting_o |-> !rdata_o[15])
    else $error("status bit wrong");
  field_store_a: assert property (wr_i && ptr_i == 2'h1
    |=> rdata_o[14:0] == $past(wdata_i[14:0])) else $error("field lost");
  wrong_ptr_a: assert property (wr_i && ptr_i != 2'h1
    |=> $stable(rdata_o[14:0])) else $error("stray write");
  ready_single_a: assert property (rdata_o[8] |-> ready_o == !converting_o)
    else $error("ready not status");
  ready_cont_a: assert property (!rdata_o[8] && converting_o
    |-> ready_o == conv_done_o) else $error("ready not pulse");
  power_down_a: assert property (conv_done_o && rdata_o[8]
    |=> !converting_o && rdata_o[15]) else $error("no power down");
endmodule : acs_setup_sva
bind acs_setup_reg acs_setup_sva i_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .ptr_i(ptr_i), .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .converting_o(converting_o), .conv_done_o(conv_done_o), .ready_o(ready_o));

// file: acs_host_model.sv
`timescale 1ns/10ps
module acs_host_model (
  input wire logic clk_i,
  output logic [1:0] ptr_o,
  output logic wr_o,
  output logic [15:0] wdata_o
);
  initial begin
    ptr_o = 2'h0;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // Returns 1 ns past the taking edge so its updates have landed
  task automatic put(input logic [1:0] p, input logic [15:0] d);
    @(posedge clk_i);
    ptr_o <= p;
    wr_o <= 1'b1;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
    #1;
  endtask : put
endmodule : acs_host_model

// file: test_acs_setup_reg.sv
`timescale 1ns/10ps
module test_acs_setup_reg;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr, done, conv, rdy;
  logic [1:0] ptr;
  logic [15:0] wd, rd;
  logic [2:0] sel, gain, rate;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int k;
  always #10 clk_i = ~clk_i;
  acs_host_model i_host (.clk_i(clk_i), .ptr_o(ptr), .wr_o(wr), .wdata_o(wd));
  // Low clock figure keeps the longest period near 250 cycles
  acs_setup_reg #(.CLK_HZ(32000)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ptr_i(ptr), .wr_i(wr), .wdata_i(wd), .rdata_o(rd), .input_select_o(sel),
    .gain_range_o(gain), .rate_o(rate), .converting_o(conv),
    .conv_done_o(done), .ready_o(rdy));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic stop_test;
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic wait_done;
    k = 0;
    while (done !== 1'b1 && k < 300) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    // A conversion that never ends is a failure, not a hang
    if (done !== 1'b1) begin
      bad_count++;
      stop_test();
    end
  endtask : wait_done
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    cmp(rd, 16'h8583);
    cmp({5'h00, sel, gain, rate, conv, rdy}, 16'h0051);
    for (int j = 0; j < 8; j++) begin
      i_host.put(2'h1, {1'b0, j[2:0], j[2:0], 1'b1, j[2:0], 5'h0a});
      cmp(rd, {1'b1, j[2:0], j[2:0], 1'b1, j[2:0], 5'h0a});
      cmp({6'h0, sel, gain, rate, conv}, {6'h0, {3{j[2:0]}}, 1'b0});
    end
    i_host.put(2'h2, 16'h0000);
    cmp(rd, 16'hffea);
    i_host.put(2'h1, 16'h85c3);
    cmp({13'h0000, conv, rdy, rd[15]}, 16'h0004);
    i_host.put(2'h1, 16'hc5c3);
    cmp({12'h000, sel, conv}, 16'h0009);
    wait_done();
    @(posedge clk_i);
    #1;
    cmp({14'h0000, conv, rdy}, 16'h0001);
    @(posedge clk_i);
    #1;
    cmp(rd, 16'hc5c3);
    i_host.put(2'h1, 16'h04c3);
    wait_done();
    cmp({14'h0000, rdy, done}, 16'h0003);
    @(posedge clk_i);
    #1;
    cmp({14'h0000, conv, rdy}, 16'h0002);
    i_host.put(2'h1, 16'h05c3);
    repeat (3) @(posedge clk_i);
    #1;
    cmp({14'h0000, conv, rdy}, 16'h0001);
    stop_test();
  end
endmodule : test_acs_setup_reg
